// file: iosp_pkg.sv
package iosp_pkg;

  //////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_NS = 1000000;
  localparam int MS_CYC = MS_NS / CLK_PERIOD_NS;
  localparam int PWM_PERIOD_NS = 64000;
  localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_PERIOD_NS;
  localparam int PWM_STEPS = 'h3ff;
  // least spacing the host keeps between sample transmissions
  localparam int TX_SPACING_MS = 20;

  //////////////////////////////////////////////////////////////////////////
  // sizes and limits
  localparam int IO_LINES = 8;
  localparam int ADC_CH = 6;
  localparam int ADC_BITS = 10;
  localparam int LEVEL_BITS = 10;
  localparam int BUF_BYTES = 93;
  localparam int BUF_AW = 7;
  localparam logic [7:0] MAX_SAMPLES = 8'h2e;
  localparam logic [7:0] MIN_SAMPLES = 8'h01;
  localparam logic [2:0] PIN_FN_RST = 3'h0;
  localparam logic [2:0] PIN_FN_PWM = 3'h2;
  localparam logic [7:0] OUT_LEVEL_RST = 8'h00;

  //////////////////////////////////////////////////////////////////////////
  // reply encoding
  localparam logic [7:0] ASCII_CR = 8'h0d;
  localparam logic [7:0] ASCII_O = 8'h4f;
  localparam logic [7:0] ASCII_K = 8'h4b;
  localparam logic [7:0] API_START = 8'h7e;
  localparam logic [7:0] API_LEN_HI = 8'h00;
  localparam logic [7:0] CKSUM_BASE = 8'hff;
  // frame type codes: arbitrary values
  localparam logic [7:0] API_TYPE_OK = 8'h01;
  localparam logic [7:0] API_TYPE_DATA = 8'h02;
  localparam logic [7:0] OK_PAYLOAD_LEN = 8'h03;
  localparam logic [7:0] DATA_HDR_LEN = 8'h04;
  localparam logic [7:0] FORCED_COUNT = 8'h01;
  localparam logic [2:0] DIGITS_COUNT = 3'h2;
  localparam logic [2:0] DIGITS_MASK = 3'h4;
  localparam logic [2:0] DIGITS_DIO = 3'h2;
  localparam logic [2:0] DIGITS_ADC = 3'h3;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CONV = 6'h02,
    ST_STORE = 6'h04,
    ST_EMIT = 6'h08,
    ST_DUMP = 6'h10,
    ST_FWD = 6'h20
  } iosp_state_t;

  function automatic logic [7:0] hexAscii(input logic [3:0] nib);
    logic [7:0] wide;
    wide = {4'h0, nib};
    hexAscii = (nib < 4'ha) ? wide + 8'h30 : wide + 8'h37;
  endfunction : hexAscii

endpackage : iosp_pkg

// file: iosp_pwm.sv
`timescale 1ns/1ps
module iosp_pwm #(
  parameter int STEPS = iosp_pkg::PWM_STEPS,
  parameter int LW = iosp_pkg::LEVEL_BITS
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic stepTick,
  input wire logic enable,
  input wire logic [LW-1:0] level,
  output logic pwmOut
);
  import iosp_pkg::*;

  logic [LW-1:0] phase_q;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= '0;
    end else if (stepTick) begin
      phase_q <= (phase_q == LW'(STEPS - 1)) ? '0 : phase_q + 1'b1;
    end
  end

  // full scale never drops: phase stops one below it
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pwmOut <= 1'b0;
    end else begin
      pwmOut <= enable && (phase_q < level);
    end
  end

endmodule : iosp_pwm

// file: iosp_buf_mem.sv
`timescale 1ns/1ps
module iosp_buf_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = iosp_pkg::BUF_BYTES,
  parameter int AW = iosp_pkg::BUF_AW
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic we,
  input wire logic [AW-1:0] wAddr,
  input wire logic [WIDTH-1:0] wData,
  input wire logic re,
  input wire logic [AW-1:0] rAddr,
  output logic [WIDTH-1:0] rData
);
  import iosp_pkg::*;

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge core_clk) begin
    if (we) begin
      mem[wAddr] <= wData;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rData <= '0;
    end else if (re) begin
      rData <= mem[rAddr];
    end
  end

endmodule : iosp_buf_mem

// file: iosp_top.sv
// Behaviour
// R1: command changes levels of output lines
// R2: eight-bit level map, output lines only
// R3: nonzero interval samples enabled lines periodically
// R4: host keeps transmissions 20 ms apart
// R5: one-sample transmit may slip interval timing
// R6: force command samples lines, replies serially
// R7: transparent reply: ASCII lines, extra CR
// R8: framed mode: OK frame, then data frame
// R9: collect 1 to 0xFF samples before transmit; the code caps the count at MAX_SAMPLES (46)
// R10: analog sample done after all channels
// R11: 93 byte buffer, at most 46 samples
// R12: stay awake until samples gathered
// R13: forward received I/O packets when enabled
// R14: host selects PWM function before first level
// R15: 64 us period of 1023 steps
// R16: duty proportional to level
// R17: host selects PWM function for second output
// R18: zero interval disables periodic sampling
`timescale 1ns/1ps
module iosp_top #(
  parameter int MS_CYCLES = iosp_pkg::MS_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic commandMode,
  input wire logic outputLevelWrite,
  input wire logic [iosp_pkg::IO_LINES-1:0] outputLevelData,
  input wire logic [iosp_pkg::IO_LINES-1:0] lineIsOutput,
  output logic [iosp_pkg::IO_LINES-1:0] digitalLinesOut,
  output logic [iosp_pkg::IO_LINES-1:0] digitalLinesOe,
  input wire logic [iosp_pkg::IO_LINES-1:0] digitalLinesIn,
  input wire logic [iosp_pkg::IO_LINES-1:0] digitalEnable,
  input wire logic [iosp_pkg::ADC_CH-1:0] analogEnable,
  input wire logic [15:0] sampleInterval,
  input wire logic [7:0] samplesPerTransmit,
  input wire logic forceSampleCmd,
  input wire logic [1:0] framedApiSelect,
  input wire logic sleepEnable,
  output logic stayAwake,
  output logic adcStart,
  output logic [2:0] adcChannel,
  input wire logic adcDone,
  input wire logic [iosp_pkg::ADC_BITS-1:0] adcData,
  output logic serValid,
  output logic [7:0] serData,
  input wire logic serReady,
  input wire logic receivedIoForwardEnable,
  input wire logic rxIoValid,
  input wire logic [7:0] rxIoData,
  input wire logic rxIoLast,
  output logic rxIoReady,
  output logic radioValid,
  output logic [7:0] radioData,
  output logic radioLast,
  output logic [7:0] radioCount,
  input wire logic radioReady,
  input wire logic [2:0] firstPwmPinFunction,
  input wire logic [2:0] secondPwmPinFunction,
  input wire logic applyChanges,
  input wire logic exitCommandMode,
  input wire logic [iosp_pkg::LEVEL_BITS-1:0] pwmFirstLevel,
  input wire logic [iosp_pkg::LEVEL_BITS-1:0] pwmSecondLevel,
  output logic pwmOutputFirst,
  output logic pwmOutputSecond
);
  import iosp_pkg::*;

  localparam int MSW = $clog2(MS_CYCLES);

  iosp_state_t state_q;
  logic [MSW-1:0] msCnt_q;
  logic [15:0] intCnt_q;
  logic due_q, forcePend_q, forced_q, apiMode_q;
  logic [IO_LINES-1:0] sync1_q, sync2_q, sync3_q, digStable_q;
  logic [IO_LINES-1:0] outLevel_q, dio_q, dioMask_q;
  logic [7:0] adcMask_q;
  logic [ADC_BITS-1:0] adcList_q [8];
  logic [2:0] chIdx_q, nAdc_q, dig_q;
  logic convBusy_q, reading_q, loaded_q, apiFrame_q;
  logic [4:0] wk_q;
  logic [BUF_AW-1:0] wrPtr_q, rdPtr_q;
  logic [7:0] count_q, sum_q;
  logic [3:0] fld_q;
  logic [5:0] bIdx_q;
  logic [12:0] pwmAcc_q;
  logic [2:0] fn1Applied_q, fn2Applied_q;

  //////////////////////////////////////////////////////////////////////////
  // timebases
  logic msTick, dueSet, startForced, startPeriodic, pwmStep;
  logic [13:0] pwmAccSum;
  assign msTick = (msCnt_q == MSW'(MS_CYCLES - 1));
  // R18: zero interval idle
  assign dueSet = msTick && (sampleInterval != 16'h0000) &&
                  (intCnt_q >= sampleInterval - 16'h0001);
  assign startForced = (state_q == ST_IDLE) && forcePend_q;
  assign startPeriodic = (state_q == ST_IDLE) && !forcePend_q && due_q;
  assign pwmAccSum = {1'b0, pwmAcc_q} + 14'(PWM_STEPS);
  // R15: fractional step divider
  assign pwmStep = (pwmAccSum >= 14'(PWM_PERIOD_CYC));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      msCnt_q <= '0;
      intCnt_q <= 16'h0000;
      pwmAcc_q <= 13'h0000;
    end else begin
      msCnt_q <= msTick ? '0 : msCnt_q + 1'b1;
      pwmAcc_q <= pwmStep ? 13'(pwmAccSum - 14'(PWM_PERIOD_CYC))
                          : pwmAccSum[12:0];
      // R3: interval in ms units
      if (sampleInterval == 16'h0000 || dueSet) begin
        intCnt_q <= 16'h0000;
      end else if (msTick) begin
        intCnt_q <= intCnt_q + 16'h0001;
      end
    end
  end

  // a request landing on its own clear is kept
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      due_q <= 1'b0;
      forcePend_q <= 1'b0;
    end else begin
      // R5: late sample waits, interval count keeps its period
      if (dueSet) begin
        due_q <= 1'b1;
      end else if (startPeriodic) begin
        due_q <= 1'b0;
      end
      // R6: force request
      if (forceSampleCmd) begin
        forcePend_q <= 1'b1;
      end else if (startForced) begin
        forcePend_q <= 1'b0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // pins, output levels, PWM
  logic [IO_LINES-1:0] agree;
  assign agree = ~(sync2_q ^ sync3_q);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      digStable_q <= '0;
      outLevel_q <= OUT_LEVEL_RST;
      fn1Applied_q <= PIN_FN_RST;
      fn2Applied_q <= PIN_FN_RST;
    end else begin
      sync1_q <= digitalLinesIn;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      digStable_q <= (sync3_q & agree) | (digStable_q & ~agree);
      // R1: command-mode level write
      // R2: bitmap hits output lines only
      if (outputLevelWrite && commandMode) begin
        outLevel_q <= (outputLevelData & lineIsOutput) |
                      (outLevel_q & ~lineIsOutput);
      end
      // R14: pin function takes effect on apply
      // R17: same for second output
      if (applyChanges || exitCommandMode) begin
        fn1Applied_q <= firstPwmPinFunction;
        fn2Applied_q <= secondPwmPinFunction;
      end
    end
  end

  assign digitalLinesOut = outLevel_q;
  assign digitalLinesOe = lineIsOutput;

  // R16: duty from level compare
  iosp_pwm u_pwm_first (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .stepTick(pwmStep),
    .enable(fn1Applied_q == PIN_FN_PWM),
    .level(pwmFirstLevel),
    .pwmOut(pwmOutputFirst)
  );

  iosp_pwm u_pwm_second (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .stepTick(pwmStep),
    .enable(fn2Applied_q == PIN_FN_PWM),
    .level(pwmSecondLevel),
    .pwmOut(pwmOutputSecond)
  );

  //////////////////////////////////////////////////////////////////////////
  // sample byte layout, shared by buffer and framed reply
  logic dioEn, memWe, memRe, slotFree, fieldIsEnd, fieldSkip;
  logic [4:0] sampleBytes, selIdx, adj, payIdx;
  logic [7:0] sampleByte, effTarget, countNext, apiLen, payload, frameByte;
  logic [7:0] txtByte;
  logic [ADC_BITS-1:0] selAdc;
  logic [3:0] adcSel, nibble;
  logic [2:0] fieldDigits, nibPos;
  logic [15:0] fieldVal;
  logic [7:0] memRData;

  assign dioEn = |dioMask_q;
  assign sampleBytes = (dioEn ? 5'h02 : 5'h00) + {1'b0, nAdc_q, 1'b0};
  assign payIdx = 5'(bIdx_q - 6'h03);
  assign selIdx = (state_q == ST_STORE) ? wk_q : payIdx - 5'h04;
  assign adj = dioEn ? selIdx : selIdx + 5'h02;
  assign selAdc = adcList_q[3'(adj[4:1] - 4'h1)];
  // R11: two bytes per conversion
  assign sampleByte = (adj < 5'h02) ? (adj[0] ? dio_q : 8'h00) :
                      (adj[0] ? selAdc[7:0] : {6'h00, selAdc[9:8]});

  // R9: transmit threshold
  // R11: capped at 46 samples
  assign effTarget = (samplesPerTransmit < MIN_SAMPLES) ? MIN_SAMPLES :
                     (samplesPerTransmit > MAX_SAMPLES) ? MAX_SAMPLES :
                     samplesPerTransmit;
  assign countNext = count_q + 8'h01;
  assign memWe = (state_q == ST_STORE) && (wk_q < sampleBytes);
  assign memRe = (state_q == ST_DUMP) && !reading_q && !loaded_q &&
                 (rdPtr_q != wrPtr_q);

  iosp_buf_mem u_buf (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .we(memWe),
    .wAddr(wrPtr_q),
    .wData(sampleByte),
    .re(memRe),
    .rAddr(rdPtr_q),
    .rData(memRData)
  );

  // transparent text fields: count, mask, dio, adc..., closing CR
  assign adcSel = fld_q - 4'h3;
  assign fieldIsEnd = (fld_q >= 4'h3) && (adcSel >= {1'b0, nAdc_q});
  assign fieldSkip = (fld_q == 4'h2) && !dioEn;
  assign fieldDigits = (fld_q == 4'h0) ? DIGITS_COUNT :
                       (fld_q == 4'h1) ? DIGITS_MASK :
                       (fld_q == 4'h2) ? DIGITS_DIO :
                       fieldIsEnd ? 3'h0 : DIGITS_ADC;
  assign fieldVal = (fld_q == 4'h0) ? {8'h00, FORCED_COUNT} :
                    (fld_q == 4'h1) ? {2'h0, adcMask_q[5:0], dioMask_q} :
                    (fld_q == 4'h2) ? {8'h00, dio_q} :
                    {6'h00, adcList_q[adcSel[2:0]]};
  assign nibPos = fieldDigits - 3'h1 - dig_q;
  assign nibble = fieldVal[{nibPos[1:0], 2'b00} +: 4];
  assign txtByte = (dig_q < fieldDigits) ? hexAscii(nibble) : ASCII_CR;

  // framed reply: start, length, payload, checksum
  assign apiLen = apiFrame_q ? DATA_HDR_LEN + {3'h0, sampleBytes}
                             : OK_PAYLOAD_LEN;
  assign payload = !apiFrame_q ? ((payIdx == 5'h00) ? API_TYPE_OK :
                                  (payIdx == 5'h01) ? ASCII_O : ASCII_K) :
                   (payIdx == 5'h00) ? API_TYPE_DATA :
                   (payIdx == 5'h01) ? FORCED_COUNT :
                   (payIdx == 5'h02) ? {2'h0, adcMask_q[5:0]} :
                   (payIdx == 5'h03) ? dioMask_q : sampleByte;
  assign frameByte = (bIdx_q == 6'h00) ? API_START :
                     (bIdx_q == 6'h01) ? API_LEN_HI :
                     (bIdx_q == 6'h02) ? apiLen :
                     ({2'h0, bIdx_q} == apiLen + 8'h03) ? CKSUM_BASE - sum_q :
                     payload;

  //////////////////////////////////////////////////////////////////////////
  // sequencer
  assign slotFree = !serValid || serReady;
  assign adcStart = (state_q == ST_CONV) && adcMask_q[chIdx_q] && !convBusy_q;
  assign rxIoReady = (state_q == ST_FWD) && slotFree;
  assign radioValid = (state_q == ST_DUMP) && loaded_q;
  assign radioData = memRData;
  assign radioLast = (rdPtr_q + 1'b1 == wrPtr_q);
  // R12: hold off sleep while a batch is open
  assign stayAwake = sleepEnable && (sampleInterval != 16'h0000) &&
                     ((count_q != 8'h00) || due_q ||
                      (state_q inside {ST_CONV, ST_STORE, ST_DUMP}));

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      {forced_q, apiMode_q, convBusy_q, reading_q, loaded_q} <= 5'h00;
      {apiFrame_q, serValid} <= 2'h0;
      {dio_q, dioMask_q, adcMask_q, serData, count_q, sum_q} <= 48'h0;
      {chIdx_q, nAdc_q, dig_q, adcChannel} <= 12'h000;
      {wk_q, fld_q, bIdx_q} <= 15'h0000;
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      radioCount <= 8'h00;
      for (int i = 0; i < 8; i++) begin
        adcList_q[i] <= '0;
      end
    end else begin
      if (serReady) begin
        serValid <= 1'b0;
      end
      adcChannel <= chIdx_q;
      unique case (state_q)
        ST_IDLE: begin
          if (startForced || startPeriodic) begin
            // R6: snapshot of enabled lines
            forced_q <= startForced;
            apiMode_q <= (framedApiSelect != 2'h0);
            dio_q <= digStable_q & digitalEnable;
            dioMask_q <= digitalEnable;
            adcMask_q <= {2'h0, analogEnable};
            {chIdx_q, nAdc_q, convBusy_q} <= 7'h00;
            {fld_q, dig_q, bIdx_q, apiFrame_q, sum_q} <= 22'h0;
            // R8: OK frame goes out before sampling
            state_q <= (startForced && framedApiSelect != 2'h0) ?
                       ST_EMIT : ST_CONV;
          end else if (rxIoValid) begin
            state_q <= ST_FWD;
          end
        end
        ST_CONV: begin
          // R10: sample complete after last channel
          if (chIdx_q == 3'(ADC_CH)) begin
            state_q <= forced_q ? ST_EMIT : ST_STORE;
            wk_q <= 5'h00;
            apiFrame_q <= apiMode_q;
          end else if (!adcMask_q[chIdx_q]) begin
            chIdx_q <= chIdx_q + 3'h1;
          end else if (!convBusy_q) begin
            convBusy_q <= 1'b1;
          end else if (adcDone) begin
            adcList_q[nAdc_q] <= adcData;
            nAdc_q <= nAdc_q + 3'h1;
            chIdx_q <= chIdx_q + 3'h1;
            convBusy_q <= 1'b0;
          end
        end
        ST_STORE: begin
          if (wk_q < sampleBytes) begin
            wk_q <= wk_q + 5'h01;
            wrPtr_q <= wrPtr_q + 1'b1;
          end else begin
            // R9: send when count reached
            // R11: or when the next sample won't fit
            count_q <= countNext;
            rdPtr_q <= '0;
            if (countNext >= effTarget ||
                {1'b0, wrPtr_q} + {3'h0, sampleBytes} > 8'(BUF_BYTES)) begin
              state_q <= ST_DUMP;
              radioCount <= countNext;
            end else begin
              state_q <= ST_IDLE;
            end
          end
        end
        ST_DUMP: begin
          if (loaded_q) begin
            if (radioReady) begin
              loaded_q <= 1'b0;
              rdPtr_q <= rdPtr_q + 1'b1;
            end
          end else if (reading_q) begin
            reading_q <= 1'b0;
            loaded_q <= 1'b1;
          end else if (rdPtr_q == wrPtr_q) begin
            wrPtr_q <= '0;
            count_q <= 8'h00;
            state_q <= ST_IDLE;
          end else begin
            reading_q <= 1'b1;
          end
        end
        ST_EMIT: begin
          if (slotFree && apiMode_q) begin
            // R8: framed OK, then framed data
            serData <= frameByte;
            serValid <= 1'b1;
            if (bIdx_q >= 6'h03) begin
              sum_q <= sum_q + payload;
            end
            if ({2'h0, bIdx_q} == apiLen + 8'h03) begin
              bIdx_q <= 6'h00;
              sum_q <= 8'h00;
              state_q <= apiFrame_q ? ST_IDLE : ST_CONV;
            end else begin
              bIdx_q <= bIdx_q + 6'h01;
            end
          end else if (slotFree && fieldSkip) begin
            fld_q <= fld_q + 4'h1;
          end else if (slotFree) begin
            // R7: hex digits, CR per field, final CR
            serData <= txtByte;
            serValid <= 1'b1;
            if (dig_q < fieldDigits) begin
              dig_q <= dig_q + 3'h1;
            end else if (fieldIsEnd) begin
              state_q <= ST_IDLE;
            end else begin
              fld_q <= fld_q + 4'h1;
              dig_q <= 3'h0;
            end
          end
        end
        ST_FWD: begin
          // R13: pass or drop received I/O packet
          if (rxIoValid && slotFree) begin
            if (receivedIoForwardEnable) begin
              serData <= rxIoData;
              serValid <= 1'b1;
            end
            if (rxIoLast) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

endmodule : iosp_top

// file: iosp_adc_model.sv
`timescale 1ns/1ps
module iosp_adc_model #(
  parameter int DELAY = 3
) (
  input wire logic core_clk,
  input wire logic adcStart,
  input wire logic [2:0] adcChannel,
  output logic adcDone,
  output logic [9:0] adcData
);
  int waitCnt = 0;
  logic answer;
  assign answer = !adcStart && waitCnt == 1;
  initial begin
    adcDone = 1'b0;
    adcData = 10'h155;
  end
  always @(posedge core_clk) begin
    adcDone <= answer;
    // data wanders outside the result cycle
    adcData <= answer ? 10'h2a0 + 10'(adcChannel) : ~adcData;
    if (adcStart) waitCnt <= DELAY;
    else if (waitCnt > 0) waitCnt <= waitCnt - 1;
  end
endmodule : iosp_adc_model

// file: iosp_top_asserts.sv
`timescale 1ns/1ps
module iosp_top_asserts #(
  parameter int MS_CYCLES = iosp_pkg::MS_CYC
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic commandMode,
  input wire logic outputLevelWrite,
  input wire logic [iosp_pkg::IO_LINES-1:0] outputLevelData,
  input wire logic [iosp_pkg::IO_LINES-1:0] lineIsOutput,
  input wire logic [iosp_pkg::IO_LINES-1:0] digitalLinesOut,
  input wire logic [15:0] sampleInterval,
  input wire logic forceSampleCmd,
  input wire logic sleepEnable,
  input wire logic stayAwake,
  input wire logic serValid,
  input wire logic [7:0] serData,
  input wire logic serReady,
  input wire logic radioValid,
  input wire logic [7:0] radioCount,
  input wire logic [2:0] firstPwmPinFunction,
  input wire logic [2:0] secondPwmPinFunction,
  input wire logic applyChanges,
  input wire logic exitCommandMode,
  input wire logic [iosp_pkg::LEVEL_BITS-1:0] pwmFirstLevel,
  input wire logic [iosp_pkg::LEVEL_BITS-1:0] pwmSecondLevel,
  input wire logic pwmOutputFirst,
  input wire logic pwmOutputSecond
);
  import iosp_pkg::*;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  logic [2:0] fnOne_q, fnTwo_q;
  // pin function only takes effect on apply or on command-mode exit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      fnOne_q <= PIN_FN_RST;
      fnTwo_q <= PIN_FN_RST;
    end else if (applyChanges || exitCommandMode) begin
      fnOne_q <= firstPwmPinFunction;
      fnTwo_q <= secondPwmPinFunction;
    end
  end
  //////////////////////////////////////////////////////////////////////////
  sequence s_lowOne;
    (fnOne_q != PIN_FN_PWM || pwmFirstLevel == 10'h000) [*3];
  endsequence
  sequence s_fullTwo;
    (fnTwo_q == PIN_FN_PWM && pwmSecondLevel == 10'h3ff) [*3];
  endsequence
  property p_lvl;
    commandMode && outputLevelWrite |=> digitalLinesOut ==
      ($past(outputLevelData) & $past(lineIsOutput)
      | $past(digitalLinesOut) & ~$past(lineIsOutput));
  endproperty
  property p_keep;
    !(commandMode && outputLevelWrite) |=> $stable(digitalLinesOut);
  endproperty
  property p_hold;
    serValid && !serReady |=> serValid && $stable(serData);
  endproperty
  property p_force;
    forceSampleCmd |-> ##[2:600] serValid;
  endproperty
  property p_awake;
    !sleepEnable || sampleInterval == 16'h0000 |-> !stayAwake;
  endproperty
  property p_awakeDump;
    sleepEnable && sampleInterval != 16'h0000 && radioValid |-> stayAwake;
  endproperty
  property p_count;
    radioValid |-> radioCount != 8'h00 && radioCount <= MAX_SAMPLES;
  endproperty
  property p_lowOne;
    s_lowOne |-> !pwmOutputFirst;
  endproperty
  property p_fullTwo;
    s_fullTwo |-> pwmOutputSecond;
  endproperty
  a_lvl: assert property (p_lvl) else $error("level write wrong");
  a_keep: assert property (p_keep) else $error("levels moved");
  a_hold: assert property (p_hold) else $error("serial byte lost");
  a_force: assert property (p_force) else $error("no reply");
  a_awake: assert property (p_awake) else $error("awake wrongly");
  a_awakeDump: assert property (p_awakeDump) else $error("asleep");
  a_count: assert property (p_count) else $error("batch size");
  a_lowOne: assert property (p_lowOne) else $error("pwm not low");
  a_fullTwo: assert property (p_fullTwo) else $error("pwm not high");
endmodule : iosp_top_asserts
bind iosp_top iosp_top_asserts #(.MS_CYCLES(MS_CYCLES)) chk (.*);

// file: tb.sv
`timescale 1ns/1ps
module tb;
  import iosp_pkg::*;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic commandMode = 1'b1;
  logic outputLevelWrite = 1'b0, forceSampleCmd = 1'b0, sleepEnable = 1'b0;
  logic serReady = 1'b1, receivedIoForwardEnable = 1'b1, radioReady = 1'b1;
  logic rxIoValid = 1'b0, rxIoLast = 1'b0;
  logic applyChanges = 1'b0, exitCommandMode = 1'b0;
  logic [7:0] outputLevelData = 8'h00, lineIsOutput = 8'h0f;
  logic [7:0] digitalLinesIn = 8'ha5, digitalEnable = 8'hff;
  logic [7:0] samplesPerTransmit = 8'h01, rxIoData = 8'h00;
  logic [5:0] analogEnable = 6'h01;
  logic [15:0] sampleInterval = 16'h0000;
  logic [1:0] framedApiSelect = 2'h0;
  logic [2:0] firstPwmPinFunction = 3'h0, secondPwmPinFunction = 3'h0;
  logic [9:0] pwmFirstLevel = 10'h000, pwmSecondLevel = 10'h000;
  logic [9:0] adcData;
  logic adcDone, adcStart, stayAwake, serValid, rxIoReady, radioValid;
  logic radioLast, pwmOutputFirst, pwmOutputSecond;
  logic [2:0] adcChannel;
  logic [7:0] digitalLinesOut, digitalLinesOe, serData, radioData, radioCount;
  logic [7:0] q[$];
  string s;
  int bad_count = 0;
  int total_checks = 0;
  int serCnt = 0;
  int h1, h2;

  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) if (serValid && serReady) serCnt++;
  iosp_top #(.MS_CYCLES(20)) dut (.*);
  iosp_adc_model #(.DELAY(3)) adc (.*);
  //////////////////////////////////////////////////////////////////////////
  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask : tick
  task automatic chk(input logic [15:0] got, exp, input string what);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    tick();
    sig = 1'b0;
    tick();
  endtask : pulse
  task automatic waitHi(ref logic sig);
    int n;
    n = 0;
    while (sig !== 1'b1 && n < 900) begin
      tick();
      n++;
    end
    chk(16'(n < 900), 16'h1, "handshake wait");
  endtask : waitHi
  task automatic ser();
    foreach (q[i]) begin
      // one stall mid-reply
      if (i == 1) begin
        serReady = 1'b0;
        repeat (3) tick();
        serReady = 1'b1;
      end
      waitHi(serValid);
      chk(16'(serData), 16'(q[i]), "serial byte");
      tick();
    end
  endtask : ser
  task automatic rx(input logic [7:0] d[$]);
    int n;
    foreach (d[i]) begin
      rxIoValid = 1'b1;
      rxIoData = d[i];
      rxIoLast = (i == d.size() - 1);
      n = 0;
      do begin
        @(posedge core_clk);
        n++;
      end while (rxIoReady !== 1'b1 && n < 900);
      #1;
      chk(16'(n < 900), 16'h1, "rx handshake");
    end
    rxIoValid = 1'b0;
    rxIoData = ~rxIoData;
  endtask : rx
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test
  initial begin
    repeat (20000) @(posedge core_clk);
    bad_count++;
    end_of_test();
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge core_clk);
    #1 rst_n = 1'b1;
    tick();
    outputLevelData = 8'hff;
    pulse(outputLevelWrite);
    chk(16'(digitalLinesOut), 16'h0f, "level write");
    commandMode = 1'b0;
    outputLevelData = 8'h00;
    pulse(outputLevelWrite);
    chk(16'(digitalLinesOut), 16'h0f, "write ignored");
    commandMode = 1'b1;
    lineIsOutput = 8'h3c;
    pulse(outputLevelWrite);
    chk(16'(digitalLinesOut), 16'h03, "masked write");
    chk(16'(digitalLinesOe), 16'h3c, "line drive");
    s = "01\01501FF\015A5\0152A0\015\015";
    foreach (s[i]) q.push_back(s[i]);
    pulse(forceSampleCmd);
    ser();
    framedApiSelect = 2'h1;
    q = {8'h7e, 8'h00, 8'h03, 8'h01, 8'h4f, 8'h4b, 8'h64, 8'h7e, 8'h00,
      8'h08, 8'h02, 8'h01, 8'h01, 8'hff, 8'h00, 8'ha5, 8'h02, 8'ha0, 8'hb5};
    pulse(forceSampleCmd);
    ser();
    q = {8'h7e, 8'h11, 8'h22};
    fork
      rx(q);
      ser();
    join
    receivedIoForwardEnable = 1'b0;
    h1 = serCnt;
    rx(q);
    repeat (5) tick();
    chk(16'(serCnt), 16'(h1), "dropped packet");
    analogEnable = 6'h00;
    samplesPerTransmit = 8'h02;
    sleepEnable = 1'b1;
    // twenty ms between batches
    sampleInterval = 16'h000a;
    for (int i = 0; i < 4; i++) begin
      waitHi(radioValid);
      if (i == 0) chk(16'(stayAwake), 16'h1, "awake");
      chk(16'(radioData), i[0] ? 16'h00a5 : 16'h0000, "radio byte");
      chk(16'(radioLast), 16'(i == 3), "radio last");
      chk(16'(radioCount), 16'h0002, "batch count");
      tick();
    end
    sampleInterval = 16'h0000;
    h1 = 0;
    repeat (300) begin
      tick();
      h1 += radioValid;
    end
    chk(16'(h1), 16'h0, "periodic off");
    chk(16'(stayAwake), 16'h0, "may sleep");
    firstPwmPinFunction = PIN_FN_PWM;
    secondPwmPinFunction = PIN_FN_PWM;
    pwmFirstLevel = 10'h1ff;
    pwmSecondLevel = 10'h3ff;
    pulse(applyChanges);
    repeat (10) tick();
    h1 = 0;
    h2 = 0;
    repeat (PWM_PERIOD_CYC) begin
      tick();
      h1 += pwmOutputFirst;
      h2 += pwmOutputSecond;
    end
    chk(16'(h1 > 3188 && h1 < 3206), 16'h1, "half duty");
    chk(16'(h2), 16'(PWM_PERIOD_CYC), "full duty");
    end_of_test();
  end
endmodule : tb
